// ==== fsr_pkg.sv ====
// shared constants and types for the request-phase link
package fsr_pkg;
    // ----------------------------------------
    // field widths and positions
    // ----------------------------------------
    localparam int ADDR_HI = 31;
    localparam int ADDR_LO = 3;
    localparam int ADDR_W = 29;           // bits 31..3 on the bus
    localparam int REQ_W = 5;             // request lines 4..0
    localparam int GRP0_W = 14;           // address bits 16..3 under strobe 0
    localparam int GRP1_W = 15;           // address bits 31..17 under strobe 1
    localparam int MASK_BIT = 20;         // address bit forced low by the mask
    localparam int MASK_IDX = 17;         // bit 20 as index into bits 31..3
    // ----------------------------------------
    // timing: the sender makes the link clock by a divider
    // ----------------------------------------
    localparam int SYS_CLK_NS = 10;
    localparam int LINK_PERIOD_NS = 160;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / SYS_CLK_NS / 2;  // 8 cycles
    localparam logic [3:0] HALF_LAST = 4'(LINK_HALF_CYC - 1);
    // last count of a strobe half period in system cycles
    localparam logic [2:0] STB_HALF_LAST = 3'h3;
    // ----------------------------------------
    // sender states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SND_IDLE = 2'b00,
        SND_SUB1 = 2'b01,
        SND_SUB2 = 2'b10,
        SND_DONE = 2'b11
    } fsr_snd_state_t;
endpackage

// ==== fsr_if.sv ====
// pin-level carrier between processor end and chipset end
`timescale 1ns/100ps
`default_nettype none
interface fsr_if;
    // bus pins other than bclk are active low; each end drives its own out or oe copy of a shared pin, resolved below
    logic bclk;                      // link clock, made by the processor end
    logic [28:0] addr_n_p_o;         // processor drive of address lines
    logic addr_n_p_oe;
    logic [28:0] addr_n_c_o;         // chipset drive of address lines
    logic addr_n_c_oe;
    logic [4:0] req_n_p_o;
    logic [4:0] req_n_c_o;
    logic [1:0] stb_n_p_o;           // addr_src_sync_strobes, processor drive
    logic [1:0] stb_n_c_o;
    logic addr_valid_strobe_n_p_o;
    logic addr_valid_strobe_n_c_o;
    logic block_next_req_n_p_o;      // open drain, low when driven
    logic block_next_req_n_p_oe;
    logic block_next_req_n_c_oe;
    logic addr_bit20_mask_n;         // chipset to processor
    // resolved wire levels
    logic [28:0] addr_n;
    logic [4:0] req_n;
    logic [1:0] stb_n;
    logic addr_valid_strobe_n;
    logic block_next_req_n;
    assign addr_n = addr_n_p_oe ? addr_n_p_o : (addr_n_c_oe ? addr_n_c_o : '1);
    assign req_n = addr_n_p_oe ? req_n_p_o : (addr_n_c_oe ? req_n_c_o : '1);
    assign stb_n = addr_n_p_oe ? stb_n_p_o : (addr_n_c_oe ? stb_n_c_o : '1);
    assign addr_valid_strobe_n = addr_valid_strobe_n_p_o & addr_valid_strobe_n_c_o;
    assign block_next_req_n = ~((block_next_req_n_p_oe & ~block_next_req_n_p_o) | block_next_req_n_c_oe);
    modport cpu (
        output bclk, addr_n_p_o, addr_n_p_oe, req_n_p_o, stb_n_p_o,
        output addr_valid_strobe_n_p_o, block_next_req_n_p_o, block_next_req_n_p_oe,
        input addr_n, req_n, stb_n, addr_valid_strobe_n, block_next_req_n, addr_bit20_mask_n
    );
    modport chipset (
        output addr_n_c_o, addr_n_c_oe, req_n_c_o, stb_n_c_o, addr_valid_strobe_n_c_o,
        output block_next_req_n_c_oe, addr_bit20_mask_n,
        input bclk, addr_n, req_n, stb_n, addr_valid_strobe_n, block_next_req_n
    );
endinterface
`default_nettype wire

// ==== fsr_cpu.sv ====
// processor end: issues requests, masks bit 20, samples straps
//
// Functional notes
// - sub-phase one drives the transaction address
// - sub-phase two drives the transaction type
// - address lines carry byte address bits 31..3
// - receiver captures address with source strobes
// - address straps sampled just after reset release
// - mask forces address bit 20 low
// - masking reproduces one-megabyte wraparound
// - mask asserted only in real mode
// - mask valid by target ready of write
// - address strobe marks a valid new request
// - agents start decode on address strobe
// - latch on both strobe edges
// - strobe 0: req, bits 16..3; strobe 1: 31..17
// - bus clock times all common-clock signals except the processor stall, which follows busy_i
// - busy agent asserts block next request
// - no new transaction during a stall; this end can still take a request in the two cycles after the line falls
`timescale 1ns/100ps
`default_nettype none
module fsr_cpu
    import fsr_pkg::*;
(
    input wire logic sys_clk_i,                 // system clock
    input wire logic resetn_i,                  // async reset, active low
    fsr_if.cpu bus,                             // bus pins
    input wire logic req_valid_i,               // request to issue
    output logic req_ready_o,                   // request taken this cycle
    input wire logic [ADDR_W-1:0] req_addr_i,   // byte address bits 31..3
    input wire logic [REQ_W-1:0] req_type_i,    // type, sub-phase 1
    input wire logic [ADDR_W-1:0] req_info_i,   // type info, sub-phase 2
    input wire logic busy_i,                    // this end cannot accept requests
    output logic [ADDR_W-1:0] strap_o,          // straps caught at reset release
    output logic strap_valid_o,                 // straps are held
    output logic [ADDR_W-1:0] lookup_addr_o,    // masked address for cache lookup
    output logic mask_active_o                  // synchronised mask level
);
    // ----------------------------------------
    // state: every register of this end in one record
    // ----------------------------------------
    typedef struct packed {
        // request sequencer
        fsr_snd_state_t st;
        // bus clock divider, then strobe and drive registers
        logic [3:0] div;
        logic bclk;
        logic [2:0] stb_cnt;
        logic [1:0] stb;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] info;
        logic [REQ_W-1:0] typ;
        logic ads;
        logic oe;
        // pin synchronisers
        logic [1:0] bnr_s;
        logic [1:0] msk_s;
        logic [1:0] rst_s;
        // straps and lookup
        logic strap_done;
        logic [ADDR_W-1:0] strap;
        logic [ADDR_W-1:0] lookup;
    } fsr_cpu_state_t;

    fsr_cpu_state_t s_r, s_nxt;
    // bclk_rise is the one-cycle enable that stands in for the bus clock edge
    logic bclk_rise;
    logic stalled;
    logic [ADDR_W-1:0] masked;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // bit 20 forced low gives the old one-megabyte wrap
    function automatic logic [ADDR_W-1:0] mask_a20(
        input logic [ADDR_W-1:0] a,
        input logic m
    );
        logic [ADDR_W-1:0] r;
        r = a;
        if (m) begin
            r[MASK_IDX] = 1'b0;
        end
        return r;
    endfunction

    // a strobe phase ends in its fourth system cycle
    function automatic logic phase_end(input logic [2:0] cnt);
        return cnt == STB_HALF_LAST;
    endfunction

    // ----------------------------------------
    // bus clock enable and request take
    // ----------------------------------------
    // lookup and bus share one masked value, so the cache never sees bit 20 set for a request taken while the mask is active
    assign masked = mask_a20(req_addr_i, s_r.msk_s[1]);
    // the enable fires in the last cycle of the low half, one cycle before the pin rises
    assign bclk_rise = (s_r.div == HALF_LAST) && !s_r.bclk;
    assign stalled = s_r.bnr_s[1];
    // requests are taken only on a bus clock rising edge while idle;
    // the stall is seen two cycles late, so a request may still leave just after it falls
    assign req_ready_o = (s_r.st == SND_IDLE) && bclk_rise && !stalled && s_r.strap_done;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        // pins are async to us: two flops before use (mask is async by design)
        s_nxt.bnr_s = {s_r.bnr_s[0], ~bus.block_next_req_n};
        s_nxt.msk_s = {s_r.msk_s[0], ~bus.addr_bit20_mask_n};
        // internal reset release, two flops behind the pin
        s_nxt.rst_s = {s_r.rst_s[0], 1'b1};
        // straps sampled while reset is just released, before anything drives;
        // requests stay refused until then, so the straps are in before this end acts
        if (!s_r.strap_done && s_r.rst_s[1]) begin
            s_nxt.strap = ~bus.addr_n;
            s_nxt.strap_done = 1'b1;
        end
        // bus clock divider
        if (s_r.div == HALF_LAST) begin
            s_nxt.div = 4'h0;
            s_nxt.bclk = ~s_r.bclk;
        end else begin
            s_nxt.div = s_r.div + 4'h1;
        end
        // phase counter, restarted at every strobe edge
        s_nxt.stb_cnt = s_r.stb_cnt + 3'h1;
        // request sequencer: take, two sub-phases, one closing phase
        case (s_r.st)
            // nothing driven while idle; a take loads address, type and info together
            SND_IDLE: begin
                s_nxt.ads = 1'b0;
                s_nxt.oe = 1'b0;
                if (req_valid_i && req_ready_o) begin
                    s_nxt.addr = masked;
                    s_nxt.lookup = masked;
                    s_nxt.typ = req_type_i;
                    s_nxt.info = req_info_i;
                    s_nxt.st = SND_SUB1;
                    s_nxt.ads = 1'b1;
                    s_nxt.oe = 1'b1;
                    s_nxt.stb = 2'b11;
                    s_nxt.stb_cnt = 3'h0;
                end
            end
            SND_SUB1: begin
                s_nxt.ads = 1'b0;
                // toggling strobe edge moves data to the second sub-phase
                if (phase_end(s_r.stb_cnt)) begin
                    s_nxt.stb = 2'b00;
                    s_nxt.stb_cnt = 3'h0;
                    s_nxt.st = SND_SUB2;
                end
            end
            // second sub-phase: type info on the lines, strobes low
            SND_SUB2: begin
                if (phase_end(s_r.stb_cnt)) begin
                    s_nxt.stb = 2'b11;
                    s_nxt.stb_cnt = 3'h0;
                    s_nxt.st = SND_DONE;
                end
            end
            // strobes back high; the lines are released after one more phase
            SND_DONE: begin
                if (phase_end(s_r.stb_cnt)) begin
                    s_nxt.oe = 1'b0;
                    s_nxt.st = SND_IDLE;
                end
            end
            default: s_nxt.st = SND_IDLE;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // async reset clears every field: active-low pins idle high, link clock low, lines released
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // pins, all active low except the link clock
    // ----------------------------------------
    // link clock comes straight from the divider flop, free of glitches
    assign bus.bclk = s_r.bclk;
    // strobe 0 covers request and bits 16..3, strobe 1 bits 31..17
    assign bus.addr_n_p_o = (s_r.st == SND_SUB1) ? ~s_r.addr : ~s_r.info;
    assign bus.addr_n_p_oe = s_r.oe;
    assign bus.req_n_p_o = ~s_r.typ;
    assign bus.stb_n_p_o = ~s_r.stb;
    assign bus.addr_valid_strobe_n_p_o = ~s_r.ads;
    // open drain stall: pulled low while this end is busy, released otherwise
    assign bus.block_next_req_n_p_o = 1'b0;
    assign bus.block_next_req_n_p_oe = busy_i;

    // local views of straps, lookup address and mask
    assign strap_o = s_r.strap;
    assign strap_valid_o = s_r.strap_done;
    assign lookup_addr_o = s_r.lookup;
    assign mask_active_o = s_r.msk_s[1];
endmodule
`default_nettype wire

// ==== fsr_chipset.sv ====
// chipset end: captures requests on strobe edges, stalls, drives mask
`timescale 1ns/100ps
`default_nettype none
module fsr_chipset
    import fsr_pkg::*;
(
    input wire logic sys_clk_i,                 // system clock
    input wire logic resetn_i,                  // async reset, active low
    fsr_if.chipset bus,                         // bus pins
    input wire logic busy_i,                    // cannot accept new requests
    input wire logic mask_i,                    // real-mode mask request
    output logic new_req_o,                     // one-cycle pulse: request captured
    output logic [ADDR_W-1:0] cap_addr_o,       // captured address bits 31..3
    output logic [REQ_W-1:0] cap_type_o,        // captured request type
    output logic [ADDR_W-1:0] cap_info_o        // captured sub-phase two info
);
    typedef struct packed {
        logic [1:0] ads_s;
        logic [1:0] stb0_s;
        logic [1:0] stb1_s;
        logic [ADDR_W-1:0] a_s1;
        logic [ADDR_W-1:0] a_s2;
        logic [REQ_W-1:0] q_s1;
        logic [REQ_W-1:0] q_s2;
        logic stb0_d;
        logic stb1_d;
        logic armed;
        logic half;
        logic pulse;
        logic [ADDR_W-1:0] addr;
        logic [REQ_W-1:0] typ;
        logic [ADDR_W-1:0] info;
        logic mask;
        logic [1:0] bclk_s;
        logic bclk_d;
        logic bnr;
    } fsr_cs_state_t;

    fsr_cs_state_t s_r, s_nxt;
    logic e0, e1;
    logic cs_live, cs_second;

    // edges of each strobe, seen after two flops
    assign e0 = s_r.stb0_s[1] ^ s_r.stb0_d;
    assign e1 = s_r.stb1_s[1] ^ s_r.stb1_d;
    // the strobe that arms capture arrives with the first edge, so that edge counts too
    assign cs_live = s_r.armed | s_r.ads_s[1];
    assign cs_second = s_r.half & ~s_r.ads_s[1];

    always_comb begin
        s_nxt = s_r;
        s_nxt.ads_s = {s_r.ads_s[0], ~bus.addr_valid_strobe_n};
        s_nxt.stb0_s = {s_r.stb0_s[0], ~bus.stb_n[0]};
        s_nxt.stb1_s = {s_r.stb1_s[0], ~bus.stb_n[1]};
        // data is held longer than the strobe path, so a matching delay is enough
        s_nxt.a_s1 = ~bus.addr_n;
        s_nxt.a_s2 = s_r.a_s1;
        s_nxt.q_s1 = ~bus.req_n;
        s_nxt.q_s2 = s_r.q_s1;
        s_nxt.stb0_d = s_r.stb0_s[1];
        s_nxt.stb1_d = s_r.stb1_s[1];
        s_nxt.bclk_s = {s_r.bclk_s[0], bus.bclk};
        s_nxt.bclk_d = s_r.bclk_s[1];
        s_nxt.pulse = 1'b0;
        s_nxt.mask = mask_i;
        if (s_r.ads_s[1]) begin
            s_nxt.armed = 1'b1;
            s_nxt.half = 1'b0;
        end
        // both edges latch: first is address, second is type info
        if (cs_live) begin
            if (e0) begin
                if (!cs_second) begin
                    s_nxt.addr[GRP0_W-1:0] = s_r.a_s2[GRP0_W-1:0];
                    s_nxt.typ = s_r.q_s2;
                end else begin
                    s_nxt.info[GRP0_W-1:0] = s_r.a_s2[GRP0_W-1:0];
                end
            end
            if (e1) begin
                if (!cs_second) begin
                    s_nxt.addr[ADDR_W-1:GRP0_W] = s_r.a_s2[ADDR_W-1:GRP0_W];
                end else begin
                    s_nxt.info[ADDR_W-1:GRP0_W] = s_r.a_s2[ADDR_W-1:GRP0_W];
                end
            end
            if (e0 || e1) begin
                s_nxt.half = ~cs_second;
                if (cs_second) begin
                    s_nxt.armed = 1'b0;
                    s_nxt.pulse = 1'b1;
                end
            end
        end
        // stall is a common-clock output: it moves only on a bus clock rise
        if (s_r.bclk_s[1] && !s_r.bclk_d) begin
            s_nxt.bnr = busy_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // pins: chipset only receives requests here
    // ----------------------------------------
    assign bus.addr_n_c_o = '1;
    assign bus.addr_n_c_oe = 1'b0;
    assign bus.req_n_c_o = '1;
    assign bus.stb_n_c_o = '1;
    assign bus.addr_valid_strobe_n_c_o = 1'b1;
    assign bus.block_next_req_n_c_oe = s_r.bnr;
    assign bus.addr_bit20_mask_n = ~s_r.mask;
    assign new_req_o = s_r.pulse;
    assign cap_addr_o = s_r.addr;
    assign cap_type_o = s_r.typ;
    assign cap_info_o = s_r.info;
endmodule
`default_nettype wire

// ==== fsr_link_monitor.sv ====
// concurrent checks on the request-phase pins between the two ends
`timescale 1ns/100ps
`default_nettype none
module fsr_link_monitor
    import fsr_pkg::*;
(
    input wire logic sys_clk_i,            // system clock
    input wire logic resetn_i,             // async reset, active low
    input wire logic bclk,                 // link clock
    input wire logic [28:0] addr_n,        // resolved address lines
    input wire logic addr_n_p_oe,          // processor drives the lines
    input wire logic [1:0] stb_n,          // resolved source strobes
    input wire logic addr_valid_strobe_n,  // resolved request strobe
    input wire logic block_next_req_n,     // resolved stall line
    input wire logic addr_bit20_mask_n     // mask level to the processor
);
    // ----------------------------------------
    // one clock domain for every check
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    a_ads_one_cycle: assert property ($fell(addr_valid_strobe_n) |=> $rose(addr_valid_strobe_n))
        else $error("request strobe not a single cycle");
    a_ads_drives_bus: assert property ($fell(addr_valid_strobe_n) |-> addr_n_p_oe && !$past(addr_n_p_oe))
        else $error("request strobe without fresh bus drive");
    a_strobe_walk_order: assert property ($fell(addr_valid_strobe_n) |-> (stb_n == 2'b00)[*4] ##1
        (stb_n == 2'b11)[*4] ##1 (stb_n == 2'b00)[*4] ##1 !addr_n_p_oe)
        else $error("strobe sequence wrong");
    a_addr_sub1_hold: assert property ($fell(addr_valid_strobe_n) |=> $stable(addr_n)[*3])
        else $error("address moved in first sub-phase");
    a_info_sub2_hold: assert property ($rose(stb_n[0]) && addr_n_p_oe |=> $stable(addr_n)[*3])
        else $error("info moved in second sub-phase");
    a_stall_blocks_req: assert property ((!block_next_req_n)[*4] |=> !$fell(addr_valid_strobe_n))
        else $error("request issued during stall");
    a_link_clk_half: assert property ($rose(bclk) |-> bclk[*8] ##1 !bclk)
        else $error("link clock high phase not eight cycles");
    a_mask_bit20_low: assert property ((!addr_bit20_mask_n)[*8] ##1 $fell(addr_valid_strobe_n)
        |-> addr_n[MASK_IDX])
        else $error("address bit 20 not masked");

    // main scenarios reached
    c_request: cover property ($fell(addr_valid_strobe_n));
    c_stall: cover property ((!block_next_req_n)[*4]);
    c_masked_req: cover property (!addr_bit20_mask_n && $fell(addr_valid_strobe_n));
endmodule
`default_nettype wire

// ==== fsr_request_phase_signalling_bench.sv ====
// self-checking bench joining processor end and chipset end
`timescale 1ns/100ps
`default_nettype none
module fsr_request_phase_signalling_bench
    import fsr_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic [28:0] req_addr_i = '0;
    logic [4:0] req_type_i = '0;
    logic [28:0] req_info_i = '0;
    logic cpu_busy = 1'b0;
    logic chip_busy = 1'b0;
    logic mask_i = 1'b0;
    logic req_ready_o, strap_valid_o, mask_active_o, new_req_o;
    logic [28:0] strap_o, lookup_addr_o, cap_addr_o, cap_info_o;
    logic [4:0] cap_type_o;
    int err_count = 0;
    int checks = 0;
    int n;

    // ----------------------------------------
    // clock, ends and checker
    // ----------------------------------------
    always #5 sys_clk_i = ~sys_clk_i;
    fsr_if bus_if ();
    fsr_cpu u_fsr_cpu (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(bus_if), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_addr_i(req_addr_i), .req_type_i(req_type_i), .req_info_i(req_info_i),
        .busy_i(cpu_busy), .strap_o(strap_o), .strap_valid_o(strap_valid_o), .lookup_addr_o(lookup_addr_o),
        .mask_active_o(mask_active_o));
    fsr_chipset u_fsr_chipset (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bus(bus_if), .busy_i(chip_busy),
        .mask_i(mask_i), .new_req_o(new_req_o), .cap_addr_o(cap_addr_o), .cap_type_o(cap_type_o),
        .cap_info_o(cap_info_o));
    fsr_link_monitor u_fsr_link_monitor (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .bclk(bus_if.bclk),
        .addr_n(bus_if.addr_n), .addr_n_p_oe(bus_if.addr_n_p_oe), .stb_n(bus_if.stb_n),
        .addr_valid_strobe_n(bus_if.addr_valid_strobe_n), .block_next_req_n(bus_if.block_next_req_n),
        .addr_bit20_mask_n(bus_if.addr_bit20_mask_n));

    // ----------------------------------------
    // comparison, closing and request tasks
    // ----------------------------------------
    task automatic check(input logic [28:0] seen, input logic [28:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // issue one request, follow it over the wire and into the chipset
    task automatic send(input logic [28:0] a, input logic [4:0] t, input logic [28:0] inf, input logic m);
        logic [28:0] ea;
        ea = m ? (a & ~(29'h1 << MASK_IDX)) : a;
        req_addr_i <= a;
        req_type_i <= t;
        req_info_i <= inf;
        req_valid_i <= 1'b1;
        n = 0;
        // ready is looked at mid-cycle; the rising edge after it takes the request
        do begin @(negedge sys_clk_i); n++; end while (req_ready_o !== 1'b1 && n < 400);
        @(posedge sys_clk_i);
        req_valid_i <= 1'b0;
        n = 0;
        do begin @(negedge sys_clk_i); n++; end while (bus_if.addr_valid_strobe_n !== 1'b0 && n < 20);
        check(bus_if.addr_n, ~ea, "sub1 address");
        check(29'(bus_if.req_n), 29'(5'(~t)), "sub1 type lines");
        check(29'(bus_if.stb_n), 29'h0, "sub1 strobes");
        repeat (4) @(negedge sys_clk_i);
        check(bus_if.addr_n, ~inf, "sub2 info");
        check(29'(bus_if.stb_n), 29'h3, "sub2 strobes");
        n = 0;
        do begin @(negedge sys_clk_i); n++; end while (new_req_o !== 1'b1 && n < 40);
        check(29'(new_req_o), 29'h1, "capture pulse");
        check(cap_addr_o, ea, "captured address");
        check(29'(cap_type_o), 29'(t), "captured type");
        check(cap_info_o, inf, "captured info");
        check(lookup_addr_o, ea, "lookup address");
        // hand back on a rising edge so the next stimulus lands there
        @(posedge sys_clk_i);
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        // released lines float high, so every strap reads zero
        check(29'(strap_valid_o), 29'h1, "strap held");
        check(strap_o, 29'h0, "strap value");
        $display("test straps done");
        // boundary values back to back, address and info swapped, then one complementary address and info pair
        send(29'h1fff_ffff, 5'h1f, 29'h0, 1'b0);
        send(29'h0, 5'h00, 29'h1fff_ffff, 1'b0);
        send(29'h0aaa_5555, 5'h15, 29'h1555_aaaa, 1'b0);
        $display("test plain requests done");
        // either end pulls the shared stall line low
        cpu_busy <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        check(29'(bus_if.block_next_req_n), 29'h0, "cpu stall level");
        cpu_busy <= 1'b0;
        chip_busy <= 1'b1;
        // chipset moves its stall only on a bus clock rise, up to one link period late
        repeat (24) @(posedge sys_clk_i);
        check(29'(bus_if.block_next_req_n), 29'h0, "chipset stall level");
        req_addr_i <= 29'h0123_4567;
        req_valid_i <= 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge sys_clk_i);
            if (req_ready_o === 1'b1) n++;
        end
        check(29'(n), 29'h0, "request taken while stalled");
        @(posedge sys_clk_i);
        chip_busy <= 1'b0;
        send(29'h0123_4567, 5'h0a, 29'h0765_4321, 1'b0);
        $display("test stall done");
        // 1 MB plus 8 wraps to byte 8 under the mask
        mask_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        check(29'(bus_if.addr_bit20_mask_n), 29'h0, "mask pin level");
        check(29'(mask_active_o), 29'h1, "mask seen");
        send(29'h0002_0001, 5'h03, 29'h0002_0001, 1'b1);
        mask_i <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        send(29'h0002_0001, 5'h03, 29'h7, 1'b0);
        $display("test mask done");
        end_sim();
    end
endmodule
`default_nettype wire
